// ===== design/gwm_top.sv
// Wake pin monitor with filters, powerup acknowledge control and APB registers
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`include "gwm_defs.svh"

module gwm_top
  import gwm_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,

  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,

  // GPIO pins
  input wire logic [`GWM_PORT_W-1:0] port_a_pins_in,
  input wire logic [`GWM_PORT_W-1:0] port_b_pins_in,
  input wire logic [`GWM_PORT_W-1:0] port_c_pins_in,
  input wire logic external_irq_line_d_in,

  // Power management state machine
  input wire logic ack_request_in,
  input wire logic powerdown_clear_in,
  output logic system_powerup_acknowledge_out,
  output logic wake_pulse_out,

  // Interrupt
  output logic irq_out
);

  // Address decode shared by read, write and error paths
  function automatic gwm_sel_t gwm_decode(input logic [31:0] addr);
    gwm_sel_t sel;
    sel = GWM_SEL_NONE;
    if (addr == `GWM_ADDR_WAKE_CTRL) begin
      sel = GWM_SEL_WAKE_CTRL;
    end else if (addr == `GWM_ADDR_WAKE_STAT) begin
      sel = GWM_SEL_WAKE_STAT;
    end else if (addr == `GWM_ADDR_ACK_STAT) begin
      sel = GWM_SEL_ACK_STAT;
    end else if (addr == `GWM_ADDR_ACK_CTRL) begin
      sel = GWM_SEL_ACK_CTRL;
    end else if (addr == `GWM_ADDR_PORT_A) begin
      sel = GWM_SEL_PORT_A;
    end else if (addr == `GWM_ADDR_PORT_B) begin
      sel = GWM_SEL_PORT_B;
    end else if (addr == `GWM_ADDR_PORT_C) begin
      sel = GWM_SEL_PORT_C;
    end else if (addr == `GWM_ADDR_FILT) begin
      sel = GWM_SEL_FILT;
    end else if (addr == `GWM_ADDR_WAKE_MASK) begin
      sel = GWM_SEL_WAKE_MASK;
    end
    return sel;
  endfunction

  // Software registers
  logic [`GWM_PORT_W-1:0] wake_enable_port_a_q;
  logic [`GWM_PORT_W-1:0] wake_enable_port_b_q;
  logic [`GWM_PORT_W-1:0] wake_enable_port_c_q;
  logic [`GWM_NSRC-1:0] wake_filter_control_q;
  logic [`GWM_NSRC-1:0] wake_control_q;
  logic [`GWM_NSRC-1:0] wake_mask_q;
  logic [`GWM_NSRC-1:0] wake_status_q;
  logic [`GWM_NSRC-1:0] wake_status_d;
  logic powerup_ack_suppress_q;
  logic ack_q;
  logic [31:0] prdata_q;
  logic wake_pulse_q;

  // Pin synchronisers and reference levels
  logic [`GWM_NPIN-1:0] sync1_q;
  logic [`GWM_NPIN-1:0] sync2_q;
  logic [`GWM_NPIN-1:0] sync3_q;
  logic [`GWM_NPIN-1:0] stable_q;
  logic [`GWM_NPIN-1:0] stable_d;
  logic [`GWM_NGPIO-1:0] ref_q;
  logic [`GWM_NSRC-1:0] filt_prev_q;

  // Bus decode
  gwm_sel_t sel;
  wire setup = psel_in && !penable_in;
  wire access = psel_in && penable_in;
  wire wr = access && pwrite_in;
  wire bad = sel == GWM_SEL_NONE;
  assign sel = gwm_decode(paddr_in);

  wire wr_port_a = wr && sel == GWM_SEL_PORT_A;
  wire wr_port_b = wr && sel == GWM_SEL_PORT_B;
  wire wr_port_c = wr && sel == GWM_SEL_PORT_C;
  wire wr_filt = wr && sel == GWM_SEL_FILT;
  wire wr_ctrl = wr && sel == GWM_SEL_WAKE_CTRL;
  wire wr_mask = wr && sel == GWM_SEL_WAKE_MASK;
  wire wr_stat = wr && sel == GWM_SEL_WAKE_STAT;
  wire wr_inhibit = wr && sel == GWM_SEL_ACK_CTRL;

  // Read mux, captured in the setup cycle
  logic [31:0] rd_word;
  always_comb begin
    rd_word = `GWM_RST_WORD;
    case (sel)
      GWM_SEL_WAKE_CTRL: rd_word[`GWM_NSRC-1:0] = wake_control_q;
      GWM_SEL_WAKE_STAT: rd_word[`GWM_NSRC-1:0] = wake_status_q;
      GWM_SEL_ACK_STAT: rd_word[`GWM_BIT_ACK] = ack_q;
      GWM_SEL_ACK_CTRL: rd_word[`GWM_BIT_INHIBIT] = powerup_ack_suppress_q;
      GWM_SEL_PORT_A: rd_word[`GWM_PORT_W-1:0] = wake_enable_port_a_q;
      GWM_SEL_PORT_B: rd_word[`GWM_PORT_W-1:0] = wake_enable_port_b_q;
      GWM_SEL_PORT_C: rd_word[`GWM_PORT_W-1:0] = wake_enable_port_c_q;
      GWM_SEL_FILT: rd_word[`GWM_NSRC-1:0] = wake_filter_control_q;
      GWM_SEL_WAKE_MASK: rd_word[`GWM_NSRC-1:0] = wake_mask_q;
      default: rd_word = `GWM_RST_WORD;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prdata_q <= `GWM_RST_WORD;
    end else if (setup && !pwrite_in) begin
      prdata_q <= rd_word;
    end
  end

  // Port enable registers keep only the eight pin bits
  wire [`GWM_PORT_W-1:0] wake_enable_port_a_d =
    wr_port_a ? pwdata_in[`GWM_PORT_W-1:0] : wake_enable_port_a_q;
  wire [`GWM_PORT_W-1:0] wake_enable_port_b_d =
    wr_port_b ? pwdata_in[`GWM_PORT_W-1:0] : wake_enable_port_b_q;
  wire [`GWM_PORT_W-1:0] wake_enable_port_c_d =
    wr_port_c ? pwdata_in[`GWM_PORT_W-1:0] : wake_enable_port_c_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wake_enable_port_a_q <= `GWM_RST_PORT;
    end else begin
      wake_enable_port_a_q <= wake_enable_port_a_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wake_enable_port_b_q <= `GWM_RST_PORT;
    end else begin
      wake_enable_port_b_q <= wake_enable_port_b_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wake_enable_port_c_q <= `GWM_RST_PORT;
    end else begin
      wake_enable_port_c_q <= wake_enable_port_c_d;
    end
  end

  // Filter, wake control and mask: reserved bits are dropped on write
  wire [`GWM_NSRC-1:0] wake_filter_control_d =
    wr_filt ? pwdata_in[`GWM_NSRC-1:0] : wake_filter_control_q;
  wire [`GWM_NSRC-1:0] wake_control_d =
    wr_ctrl ? pwdata_in[`GWM_NSRC-1:0] : wake_control_q;
  wire [`GWM_NSRC-1:0] wake_mask_d =
    wr_mask ? pwdata_in[`GWM_NSRC-1:0] : wake_mask_q;

  // Filters come out of reset enabled
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wake_filter_control_q <= `GWM_RST_FILT;
    end else begin
      wake_filter_control_q <= wake_filter_control_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wake_control_q <= `GWM_RST_CTRL;
    end else begin
      wake_control_q <= wake_control_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wake_mask_q <= `GWM_RST_MASK;
    end else begin
      wake_mask_q <= wake_mask_d;
    end
  end

  // Inhibit: the power-down clear beats a simultaneous software write
  wire powerup_ack_suppress_d = powerdown_clear_in ? 1'h0 :
    wr_inhibit ? pwdata_in[`GWM_BIT_INHIBIT] : powerup_ack_suppress_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      powerup_ack_suppress_q <= `GWM_RST_FLAG;
    end else begin
      powerup_ack_suppress_q <= powerup_ack_suppress_d;
    end
  end

  // Acknowledge follows the request unless suppressed
  wire ack_d = ack_request_in && !powerup_ack_suppress_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ack_q <= `GWM_RST_FLAG;
    end else begin
      ack_q <= ack_d;
    end
  end

  // Three-stage pin capture; a change counts when stages two and three agree
  wire [`GWM_NPIN-1:0] pins_raw = {external_irq_line_d_in, port_c_pins_in,
                                   port_b_pins_in, port_a_pins_in};
  wire [`GWM_NPIN-1:0] agree = ~(sync2_q ^ sync3_q);
  assign stable_d = (agree & sync3_q) | (~agree & stable_q);

  // Only stage two reads stage one, to keep metastability contained
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Held level moves only once stages two and three agree
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stable_q <= '0;
    end else begin
      stable_q <= stable_d;
    end
  end

  // Pin-change source: any enabled pin differing from its reference
  wire [`GWM_NGPIO-1:0] gpio_now = stable_q[`GWM_NGPIO-1:0];
  wire [`GWM_NGPIO-1:0] pin_en = {wake_enable_port_c_q, wake_enable_port_b_q,
                                     wake_enable_port_a_q};
  wire global_en = wake_control_q[`GWM_BIT_GLOBAL_EN];
  wire pin_change_raw = |((gpio_now ^ ref_q) & pin_en);

  gwm_src_t src_raw;
  gwm_src_t src_filt;
  assign src_raw.pin_change = pin_change_raw;
  assign src_raw.serial_one = gpio_now[`GWM_PORT_W + `GWM_PIN_SERIAL];
  assign src_raw.serial_two = gpio_now[`GWM_PIN_SERIAL];
  assign src_raw.irq_d = stable_q[`GWM_NPIN-1];

  // One filter per source, enabled by its filter control bit
  generate
    for (genvar i = 0; i < `GWM_NSRC; i++) begin : g_filt
      gwm_filter u_filt (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .filt_en_in(wake_filter_control_q[i]),
        .level_in(src_raw[i]),
        .level_out(src_filt[i])
      );
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      filt_prev_q <= '0;
    end else begin
      filt_prev_q <= src_filt;
    end
  end

  // Wake events
  wire pin_event = global_en && src_filt.pin_change && !filt_prev_q[`GWM_SRC_PIN];
  wire [`GWM_NSRC-1:0] edge_seen = src_filt ^ filt_prev_q;
  wire [`GWM_NSRC-1:0] events = {
    edge_seen[`GWM_SRC_LINE_D] && wake_control_q[`GWM_SRC_LINE_D],
    edge_seen[`GWM_SRC_SER2] && wake_control_q[`GWM_SRC_SER2],
    edge_seen[`GWM_SRC_SER1] && wake_control_q[`GWM_SRC_SER1],
    pin_event
  };

  // Reference catches up after a wake, and tracks while monitoring is off
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ref_q <= '0;
    end else if (pin_event || !global_en) begin
      ref_q <= gpio_now;
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  wire [`GWM_NSRC-1:0] clr = wr_stat ? pwdata_in[`GWM_NSRC-1:0] : '0;
  assign wake_status_d = (wake_status_q & ~clr) | events;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wake_status_q <= `GWM_RST_STAT;
    end else begin
      wake_status_q <= wake_status_d;
    end
  end

  // One-cycle wake request to the power state machine
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wake_pulse_q <= `GWM_RST_FLAG;
    end else begin
      wake_pulse_q <= |events;
    end
  end

  // Outputs
  assign prdata_out = prdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = access && bad;
  assign system_powerup_acknowledge_out = ack_q;
  assign wake_pulse_out = wake_pulse_q;
  assign irq_out = |(wake_status_q & wake_mask_q);

endmodule

// ===== design/gwm_defs.svh
// Address map, field positions, reset values and timing for the wake monitor
`ifndef GWM_DEFS_SVH
`define GWM_DEFS_SVH

// Register byte addresses
`define GWM_ADDR_WAKE_CTRL 32'h4000_0020
`define GWM_ADDR_WAKE_STAT 32'h4000_0028
`define GWM_ADDR_ACK_STAT 32'h4000_003C
`define GWM_ADDR_ACK_CTRL 32'h4000_0040
`define GWM_ADDR_PORT_A 32'h4000_BC08
`define GWM_ADDR_PORT_B 32'h4000_BC0C
`define GWM_ADDR_PORT_C 32'h4000_BC10
`define GWM_ADDR_FILT 32'h4000_BC1C
`define GWM_ADDR_WAKE_MASK 32'h4000_BC20

// Field layout
`define GWM_PORT_W 8
`define GWM_NSRC 4
`define GWM_SRC_PIN 0
`define GWM_SRC_SER1 1
`define GWM_SRC_SER2 2
`define GWM_SRC_LINE_D 3
`define GWM_BIT_ACK 0
`define GWM_BIT_INHIBIT 0
`define GWM_BIT_GLOBAL_EN 0
`define GWM_PIN_SERIAL 2
`define GWM_NPIN 25
`define GWM_NPORT 3
`define GWM_NGPIO (`GWM_NPORT * `GWM_PORT_W)

// Reset values
`define GWM_RST_PORT 8'h00
`define GWM_RST_FILT 4'hF
`define GWM_RST_CTRL 4'h0
`define GWM_RST_MASK 4'h0
`define GWM_RST_STAT 4'h0
`define GWM_RST_WORD 32'h0000_0000
`define GWM_RST_FLAG 1'h0

// Filter timing: least pulse length accepted
`define GWM_CLK_MHZ 50
`define GWM_FILT_NS 100
`define GWM_FILT_CYC (((`GWM_FILT_NS * `GWM_CLK_MHZ) + 999) / 1000)
`define GWM_FILT_CW 3

`endif

// ===== design/gwm_pkg.sv
// Types shared by the wake monitor modules
package gwm_pkg;

  // Wake sources, one bit each, in status bit order
  typedef struct packed {
    logic irq_d;
    logic serial_two;
    logic serial_one;
    logic pin_change;
  } gwm_src_t;

  // Register selected by an APB address
  typedef enum logic [3:0] {
    GWM_SEL_NONE = 4'h0,
    GWM_SEL_WAKE_CTRL = 4'h1,
    GWM_SEL_WAKE_STAT = 4'h2,
    GWM_SEL_ACK_STAT = 4'h3,
    GWM_SEL_ACK_CTRL = 4'h4,
    GWM_SEL_PORT_A = 4'h5,
    GWM_SEL_PORT_B = 4'h6,
    GWM_SEL_PORT_C = 4'h7,
    GWM_SEL_FILT = 4'h8,
    GWM_SEL_WAKE_MASK = 4'h9
  } gwm_sel_t;

endpackage

// ===== design/gwm_filter.sv
// Glitch filter: a level is accepted only after it holds for a set time
`timescale 1ns/1ns
`include "gwm_defs.svh"

module gwm_filter
  import gwm_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control and data
  input wire logic filt_en_in,
  input wire logic level_in,
  output logic level_out
);

  localparam logic [`GWM_FILT_CW-1:0] LAST = `GWM_FILT_CW'(`GWM_FILT_CYC - 1);

  logic level_q;
  logic [`GWM_FILT_CW-1:0] cnt_q;

  wire differ = level_in != level_q;
  wire done = cnt_q == LAST;

  // Unfiltered: follow input; filtered: change only after a full hold
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      level_q <= 1'b0;
      cnt_q <= '0;
    end else if (!filt_en_in) begin
      level_q <= level_in;
      cnt_q <= '0;
    end else if (!differ) begin
      cnt_q <= '0;
    end else if (done) begin
      level_q <= level_in;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + `GWM_FILT_CW'(1);
    end
  end

  assign level_out = level_q;

endmodule

// ===== test/gwm_top_properties.sv
// Concurrent checks on the wake monitor ports
`timescale 1ns/1ns
`include "gwm_defs.svh"

module gwm_top_checker (
  // Clock, reset and APB
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pslverr_out,
  // Pins and power control
  input wire logic [`GWM_PORT_W-1:0] port_a_pins_in,
  input wire logic [`GWM_PORT_W-1:0] port_b_pins_in,
  input wire logic [`GWM_PORT_W-1:0] port_c_pins_in,
  input wire logic external_irq_line_d_in,
  input wire logic ack_request_in,
  input wire logic powerdown_clear_in,
  input wire logic system_powerup_acknowledge_out,
  input wire logic wake_pulse_out,
  input wire logic irq_out
);
  logic [24:0] pins_q;
  logic [4:0] quiet_q;
  wire [24:0] pins_w = {external_irq_line_d_in, port_c_pins_in, port_b_pins_in, port_a_pins_in};
  wire access_w = psel_in && penable_in;
  wire read_w = access_w && !pwrite_in;
  wire port_w = paddr_in inside {`GWM_ADDR_PORT_A, `GWM_ADDR_PORT_B, `GWM_ADDR_PORT_C};
  wire mapped_w = port_w || paddr_in inside {`GWM_ADDR_WAKE_CTRL, `GWM_ADDR_WAKE_STAT,
    `GWM_ADDR_ACK_STAT, `GWM_ADDR_ACK_CTRL, `GWM_ADDR_FILT, `GWM_ADDR_WAKE_MASK};

  // Cycles since the last pin change or register write
  always_ff @(posedge clk_in) begin
    pins_q <= pins_w;
    if (!rst_n_in || pins_w != pins_q || (access_w && pwrite_in)) quiet_q <= 5'h00;
    else if (quiet_q != 5'h1F) quiet_q <= quiet_q + 5'h01;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_ack_needs_req: assert property (system_powerup_acknowledge_out |-> $past(ack_request_in))
    else $error("acknowledge without request");
  a_ack_drops_now: assert property (!ack_request_in |=> !system_powerup_acknowledge_out)
    else $error("acknowledge stayed after request fell");
  a_ack_after_clear: assert property ((ack_request_in && powerdown_clear_in) ##1 ack_request_in
    |=> system_powerup_acknowledge_out) else $error("inhibit not cleared by power-down");
  a_ack_status_read: assert property (read_w && paddr_in == `GWM_ADDR_ACK_STAT
    && $stable(system_powerup_acknowledge_out)
    |-> prdata_out == {31'h0, system_powerup_acknowledge_out}) else $error("ack status wrong");
  a_port_read_width: assert property (read_w && port_w |-> prdata_out[31:8] == 24'h0)
    else $error("port enable read has upper bits");
  a_quiet_no_wake: assert property (quiet_q >= 5'h14 |-> !wake_pulse_out)
    else $error("wake without a pin change");
  a_irq_has_cause: assert property ($rose(irq_out)
    |-> wake_pulse_out || $past(access_w && pwrite_in)) else $error("irq without event");
  a_error_unmapped: assert property (pslverr_out == (access_w && !mapped_w))
    else $error("slave error wrong");

  c_wake: cover property (wake_pulse_out);
  c_irq: cover property ($rose(irq_out));
  c_error: cover property (access_w && pslverr_out);
endmodule

bind gwm_top gwm_top_checker i_checker (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pslverr_out(pslverr_out), .port_a_pins_in(port_a_pins_in),
  .port_b_pins_in(port_b_pins_in), .port_c_pins_in(port_c_pins_in),
  .external_irq_line_d_in(external_irq_line_d_in), .ack_request_in(ack_request_in),
  .powerdown_clear_in(powerdown_clear_in), .wake_pulse_out(wake_pulse_out),
  .system_powerup_acknowledge_out(system_powerup_acknowledge_out), .irq_out(irq_out));

// ===== test/gwm_far_model.sv
// Far side model: GPIO pin drivers and power state machine handshake
`timescale 1ns/1ns

module gwm_far_model (
  // Bench commands
  input wire logic [24:0] level_in,
  input wire logic req_in,
  input wire logic sleep_in,
  // Pins and power control
  output logic [7:0] pa_out,
  output logic [7:0] pb_out,
  output logic [7:0] pc_out,
  output logic line_d_out,
  output logic ack_req_out,
  output logic pd_clear_out
);
  assign {line_d_out, pc_out, pb_out, pa_out} = level_in;
  assign ack_req_out = req_in;
  // Power-down step clears the inhibit
  assign pd_clear_out = sleep_in;
endmodule

// ===== test/gwm_top_test.sv
// Self-checking bench for the wake monitor
`timescale 1ns/1ns
`include "gwm_defs.svh"

module gwm_top_test;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [24:0] lvl = 25'h0;
  logic req = 1'b0;
  logic sleep = 1'b0;
  logic [31:0] seed = 32'h817BA00D;
  logic [31:0] rdata;
  logic [31:0] dat;
  logic rerr;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int k;
  wire [31:0] prdata_out;
  wire [7:0] pa;
  wire [7:0] pb;
  wire [7:0] pc;
  wire pready_out, pslverr_out, line_d, ack_req, pd_clr, ack_out, wake_pulse_out, irq_out;
  logic [31:0] addr_t [9] = '{`GWM_ADDR_WAKE_CTRL, `GWM_ADDR_WAKE_STAT, `GWM_ADDR_ACK_STAT,
    `GWM_ADDR_ACK_CTRL, `GWM_ADDR_PORT_A, `GWM_ADDR_PORT_B, `GWM_ADDR_PORT_C,
    `GWM_ADDR_FILT, `GWM_ADDR_WAKE_MASK};

  gwm_far_model i_far (.level_in(lvl), .req_in(req), .sleep_in(sleep), .pa_out(pa),
    .pb_out(pb), .pc_out(pc), .line_d_out(line_d), .ack_req_out(ack_req), .pd_clear_out(pd_clr));

  gwm_top i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .port_a_pins_in(pa),
    .port_b_pins_in(pb), .port_c_pins_in(pc), .external_irq_line_d_in(line_d),
    .ack_request_in(ack_req), .powerdown_clear_in(pd_clr),
    .system_powerup_acknowledge_out(ack_out), .wake_pulse_out(wake_pulse_out),
    .irq_out(irq_out));

  always #10 clk_in = ~clk_in;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Pin index of each wake source, status bit order
  function automatic int src_pin(input int s);
    return s == 0 ? 0 : s == 1 ? 10 : s == 2 ? 2 : 24;
  endfunction

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    rdata = prdata_out;
    rerr = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(name, e, rdata);
  endtask

  task automatic flip(input int idx, input int len);
    @(posedge clk_in);
    lvl[idx] <= ~lvl[idx];
    if (len > 0) begin
      repeat (len) @(posedge clk_in);
      lvl[idx] <= ~lvl[idx];
    end
  endtask

  task automatic watch(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (40) begin
      @(posedge clk_in);
      if (wake_pulse_out === 1'b1) seen = 1'b1;
    end
    chk("wake pulse", {31'h0, e}, {31'h0, seen});
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 9; i++) rd_chk("reset", addr_t[i], i == 7 ? 32'hF : 32'h0);
    rd_chk("unmapped", 32'h4000_BC14, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    for (int p = 0; p < 3; p++) begin
      seed = xs(seed);
      dat = seed & 32'hFF;
      apb(1'b1, addr_t[4+p], dat);
      rd_chk("port enables", addr_t[4+p], dat);
    end
    $display("test registers done");
    apb(1'b1, `GWM_ADDR_ACK_CTRL, 32'h1);
    req <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk("ack inhibited", 32'h0, {31'h0, ack_out});
    rd_chk("ack status", `GWM_ADDR_ACK_STAT, 32'h0);
    apb(1'b1, `GWM_ADDR_ACK_CTRL, 32'h0);
    repeat (2) @(posedge clk_in);
    chk("ack allowed", 32'h1, {31'h0, ack_out});
    rd_chk("ack status", `GWM_ADDR_ACK_STAT, 32'h1);
    apb(1'b1, `GWM_ADDR_ACK_CTRL, 32'h1);
    sleep <= 1'b1;
    @(posedge clk_in);
    sleep <= 1'b0;
    rd_chk("inhibit cleared", `GWM_ADDR_ACK_CTRL, 32'h0);
    chk("ack after clear", 32'h1, {31'h0, ack_out});
    $display("test acknowledge done");
    for (int p = 0; p < 3; p++) begin
      seed = xs(seed);
      k = seed[2:0];
      for (int q = 0; q < 3; q++) apb(1'b1, addr_t[4+q], q == p ? 32'h1 << k : 32'h0);
      apb(1'b1, `GWM_ADDR_WAKE_STAT, 32'hF);
      apb(1'b1, `GWM_ADDR_WAKE_MASK, 32'h1);
      apb(1'b1, `GWM_ADDR_WAKE_CTRL, 32'h1);
      flip(8 * p + k, 0);
      watch(1'b1);
      rd_chk("pin flag", `GWM_ADDR_WAKE_STAT, 32'h1);
      chk("irq set", 32'h1, {31'h0, irq_out});
      apb(1'b1, `GWM_ADDR_WAKE_STAT, 32'h1);
      @(posedge clk_in);
      chk("irq cleared", 32'h0, {31'h0, irq_out});
      flip(8 * p + (k ^ 1), 0);
      watch(1'b0);
      apb(1'b1, `GWM_ADDR_WAKE_CTRL, 32'h0);
      flip(8 * p + k, 0);
      watch(1'b0);
    end
    $display("test pin wake done");
    apb(1'b1, addr_t[5], 32'h0);
    apb(1'b1, addr_t[6], 32'h0);
    apb(1'b1, `GWM_ADDR_WAKE_MASK, 32'h0);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, addr_t[4], s == 0 ? 32'h1 : 32'h0);
      apb(1'b1, `GWM_ADDR_WAKE_CTRL, 32'h1 << s);
      apb(1'b1, `GWM_ADDR_FILT, 32'hF);
      flip(src_pin(s), 3);
      watch(1'b0);
      apb(1'b1, `GWM_ADDR_FILT, 32'h0);
      flip(src_pin(s), 3);
      watch(1'b1);
      rd_chk("source flag", `GWM_ADDR_WAKE_STAT, 32'h1 << s);
      chk("irq masked", 32'h0, {31'h0, irq_out});
      apb(1'b1, `GWM_ADDR_WAKE_STAT, 32'hF);
      apb(1'b1, `GWM_ADDR_FILT, 32'hF);
      flip(src_pin(s), 0);
      watch(1'b1);
      rd_chk("filtered flag", `GWM_ADDR_WAKE_STAT, 32'h1 << s);
      apb(1'b1, `GWM_ADDR_WAKE_STAT, 32'hF);
    end
    $display("test filters done");
    report_and_stop();
  end
endmodule
